// *** logic/gupc_pkg.sv ***
// Purpose: shared constants and types of the gated up/down pulse counter
// Assumes: signed 32-bit two's complement count values
// Notes:   all state of the counter travels as one packed struct
package gupc_pkg;

    // ------------------------------------------------------------------
    // count range and reset values
    // ------------------------------------------------------------------
    localparam int             CNT_W     = 32;
    localparam logic [31:0]    LIMIT_MIN = 32'h8000_0000;
    localparam logic [31:0]    LIMIT_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0]    ONE       = 32'h0000_0001;
    localparam logic [31:0]    COUNT_RST = 32'h0000_0000;
    localparam int             SYNC_LEN  = 3;

    // ------------------------------------------------------------------
    // operating mode and main direction encodings
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        GUPC_MODE_CONT   = 2'b00,
        GUPC_MODE_SINGLE = 2'b01,
        GUPC_MODE_PERIOD = 2'b10
    } gupc_mode_t;

    typedef enum logic [1:0] {
        GUPC_DIR_NONE = 2'b00,
        GUPC_DIR_FWD  = 2'b01,
        GUPC_DIR_BWD  = 2'b10
    } gupc_dir_t;

    // configuration from the control program
    typedef struct packed {
        gupc_mode_t  mode;
        gupc_dir_t   main_dir;
        logic        hardware_gate_input_en;
        logic        abort_mode;
        logic        irq_en;
        logic [31:0] load_value;
        logic [31:0] end_value;
    } gupc_cfg_t;

    // status back to the control program
    typedef struct packed {
        logic [31:0] count;
        logic        overflow_flag;
        logic        underflow_flag;
        logic        gate_open;
        logic        process_irq;
    } gupc_sts_t;

    // whole counter state
    typedef struct packed {
        logic [2:0]  up_sync;
        logic [2:0]  dn_sync;
        logic [2:0]  hw_sync;
        logic        up_prev;
        logic        dn_prev;
        logic        hw_lvl;
        logic        sw_prev;
        logic        igate_prev;
        logic        auto_closed;
        logic        closed_hw_seen;
        gupc_sts_t   sts;
    } gupc_state_t;

endpackage

// *** logic/gupc_counter.sv ***
// Purpose: signed 32-bit gated up/down pulse counter channel
// Assumes: pulse and hardware gate pins are asynchronous, program bits are synchronous
// Notes:   one count per synchronised rising edge of the up or down pulse pin
//
// What this block does
// - no main direction: full signed 32-bit range
// - forward, single or periodic: after end minus one, reload
// - backwards, single or periodic: after end plus one, reload
// - hardware gate on: restart rules on its openings
// - abort gate: reopening reloads load value
// - interrupt gate: hold while closed, resume
// - continuous: upper limit wraps to lower
// - continuous: lower limit wraps to upper
// - sticky overflow/underflow until status clear
// - process interrupt on flag set if enabled
// - single, no direction: wrap, close gate, flag
// - after auto close: stopped until reopened
// - single forward: reload and close at end
// - after auto close: rising gate edge, load with a main direction or abort
// - single backwards: reload and close at end
// - periodic, no direction: wrap, no closure
// - periodic forward: reload after end minus one
// - periodic backwards: reload, upward wrap allowed
`timescale 1ns/1ps

module gupc_counter
(
    input  wire logic               mclk_in,
    input  wire logic               rst_in,
    input  wire logic               count_up_in,
    input  wire logic               count_down_in,
    input  wire logic               hardware_gate_input_in,
    input  wire logic               program_gate_bit_in,
    input  wire logic               status_clear_request_in,
    input  wire gupc_pkg::gupc_cfg_t cfg_in,
    output gupc_pkg::gupc_sts_t     sts_out
);

    // ------------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------------
    gupc_pkg::gupc_state_t state_q;
    gupc_pkg::gupc_state_t state_d;

    // helper values for the next-state logic
    logic        up_ev;
    logic        dn_ev;
    logic        hw_rise;
    logic        sw_rise;
    logic        igate;
    logic        gate_rise;
    logic        restart_ev;
    logic        reopen_ok;
    logic        ovf;
    logic        unf;
    logic        close_now;
    logic [31:0] cnt;
    logic [31:0] nxt;
    logic [31:0] end_m1;
    logic [31:0] end_p1;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        cnt     = state_q.sts.count;
        nxt     = cnt;
        ovf     = 1'b0;
        unf     = 1'b0;
        close_now = 1'b0;
        end_m1  = cfg_in.end_value - gupc_pkg::ONE;
        end_p1  = cfg_in.end_value + gupc_pkg::ONE;

        // three-stage synchronisers; change taken when stages two and three agree
        state_d.up_sync = {state_q.up_sync[1:0], count_up_in};
        state_d.dn_sync = {state_q.dn_sync[1:0], count_down_in};
        state_d.hw_sync = {state_q.hw_sync[1:0], hardware_gate_input_in};
        if (state_q.up_sync[2] == state_q.up_sync[1])
        begin
            state_d.up_prev = state_q.up_sync[2];
        end
        if (state_q.dn_sync[2] == state_q.dn_sync[1])
        begin
            state_d.dn_prev = state_q.dn_sync[2];
        end
        if (state_q.hw_sync[2] == state_q.hw_sync[1])
        begin
            state_d.hw_lvl = state_q.hw_sync[2];
        end
        up_ev   = state_d.up_prev & ~state_q.up_prev;
        dn_ev   = state_d.dn_prev & ~state_q.dn_prev;
        hw_rise = state_d.hw_lvl & ~state_q.hw_lvl;
        sw_rise = program_gate_bit_in & ~state_q.sw_prev;
        state_d.sw_prev = program_gate_bit_in;

        // internal gate from program bit and optional hardware gate
        igate     = program_gate_bit_in & (~cfg_in.hardware_gate_input_en | state_d.hw_lvl);
        gate_rise = igate & ~state_q.igate_prev;
        state_d.igate_prev = igate;
        // restart reaction follows hardware gate openings only when enabled
        restart_ev = cfg_in.hardware_gate_input_en ? (hw_rise & program_gate_bit_in) : sw_rise;

        // reopening after auto close needs a fresh hardware edge when enabled
        if (state_q.auto_closed && hw_rise)
        begin
            state_d.closed_hw_seen = 1'b1;
        end
        reopen_ok = cfg_in.hardware_gate_input_en ? (state_d.closed_hw_seen & gate_rise)
                                      : gate_rise;

        if (state_q.auto_closed)
        begin
            // stopped until the gate sees a new rising edge
            if (reopen_ok)
            begin
                state_d.auto_closed    = 1'b0;
                state_d.closed_hw_seen = 1'b0;
                if (cfg_in.main_dir != gupc_pkg::GUPC_DIR_NONE || cfg_in.abort_mode)
                begin
                    nxt = cfg_in.load_value;
                end
            end
        end
        else if (restart_ev && cfg_in.abort_mode)
        begin
            nxt = cfg_in.load_value;
        end
        else if (igate && (up_ev ^ dn_ev))
        begin
            // gate closed leaves the count held
            if (up_ev)
            begin
                if (cfg_in.mode != gupc_pkg::GUPC_MODE_CONT
                    && cfg_in.main_dir == gupc_pkg::GUPC_DIR_FWD && cnt == end_m1)
                begin
                    nxt = cfg_in.load_value;
                    close_now = (cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE);
                end
                else if (cnt == gupc_pkg::LIMIT_MAX)
                begin
                    nxt = gupc_pkg::LIMIT_MIN;
                    ovf = 1'b1;
                    close_now = (cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE);
                end
                else
                begin
                    nxt = cnt + gupc_pkg::ONE;
                end
            end
            else
            begin
                if (cfg_in.mode != gupc_pkg::GUPC_MODE_CONT
                    && cfg_in.main_dir == gupc_pkg::GUPC_DIR_BWD && cnt == end_p1)
                begin
                    nxt = cfg_in.load_value;
                    close_now = (cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE);
                end
                else if (cnt == gupc_pkg::LIMIT_MIN)
                begin
                    nxt = gupc_pkg::LIMIT_MAX;
                    unf = 1'b1;
                    close_now = (cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE);
                end
                else
                begin
                    nxt = cnt - gupc_pkg::ONE;
                end
            end
        end
        state_d.sts.count = nxt;
        if (close_now)
        begin
            state_d.auto_closed    = 1'b1;
            state_d.closed_hw_seen = 1'b0;
        end

        // sticky flags: a set in the clear cycle wins
        state_d.sts.overflow_flag  = ovf | (state_q.sts.overflow_flag & ~status_clear_request_in);
        state_d.sts.underflow_flag = unf | (state_q.sts.underflow_flag & ~status_clear_request_in);
        state_d.sts.process_irq    = cfg_in.irq_en & (ovf | unf);
        state_d.sts.gate_open      = igate & ~state_d.auto_closed;
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    assign sts_out = state_q.sts;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence s_up_at_max;
        igate && up_ev && !dn_ev && !state_q.auto_closed && !restart_ev
        && cnt == gupc_pkg::LIMIT_MAX && !(cfg_in.mode != gupc_pkg::GUPC_MODE_CONT
        && cfg_in.main_dir == gupc_pkg::GUPC_DIR_FWD && cnt == end_m1);
    endsequence

    up_wrap_a: assert property (s_up_at_max |=> sts_out.count == gupc_pkg::LIMIT_MIN
        && sts_out.overflow_flag)
        else $error("upper wrap missing");

    down_wrap_a: assert property (igate && dn_ev && !up_ev && !state_q.auto_closed
        && !restart_ev && cnt == gupc_pkg::LIMIT_MIN && cfg_in.main_dir != gupc_pkg::GUPC_DIR_BWD
        |=> sts_out.count == gupc_pkg::LIMIT_MAX && sts_out.underflow_flag)
        else $error("lower wrap missing");

    flag_sticky_a: assert property (sts_out.overflow_flag && !status_clear_request_in
        |=> sts_out.overflow_flag)
        else $error("overflow flag lost");

    irq_cause_a: assert property (sts_out.process_irq |-> $rose(sts_out.overflow_flag)
        || $rose(sts_out.underflow_flag) || $past(ovf) || $past(unf))
        else $error("interrupt without cause");

    hold_closed_a: assert property (!igate && !restart_ev |=> $stable(sts_out.count))
        else $error("count moved with gate closed");

    stopped_a: assert property (state_q.auto_closed && !reopen_ok
        |=> $stable(sts_out.count))
        else $error("count moved after auto close");

    single_close_a: assert property (cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE && close_now
        |=> state_q.auto_closed && !sts_out.gate_open)
        else $error("single mode did not close");

    step_one_a: assert property (igate && !state_q.auto_closed && !restart_ev && up_ev
        && !dn_ev && !close_now && !ovf && cnt != end_m1
        |=> sts_out.count == $past(cnt) + gupc_pkg::ONE)
        else $error("step not one");

    abort_load_a: assert property (!state_q.auto_closed && restart_ev && cfg_in.abort_mode
        |=> sts_out.count == $past(cfg_in.load_value))
        else $error("abort did not reload");

    // ------------------------------------------------------------------
    // end-value reloads with a main direction
    // ------------------------------------------------------------------
    // up pulse that lands on end minus one outside continuous mode
    sequence s_fwd_end;
        igate && up_ev && !dn_ev && !state_q.auto_closed && !restart_ev
        && cfg_in.mode != gupc_pkg::GUPC_MODE_CONT
        && cfg_in.main_dir == gupc_pkg::GUPC_DIR_FWD && cnt == end_m1;
    endsequence

    // down pulse that lands on end plus one outside continuous mode
    sequence s_bwd_end;
        igate && dn_ev && !up_ev && !state_q.auto_closed && !restart_ev
        && cfg_in.mode != gupc_pkg::GUPC_MODE_CONT
        && cfg_in.main_dir == gupc_pkg::GUPC_DIR_BWD && cnt == end_p1;
    endsequence

    // forward range jumps back to the load value
    fwd_reload_a: assert property (s_fwd_end
        |=> sts_out.count == $past(cfg_in.load_value))
        else $error("forward end reload missing");

    // backward range jumps back to the load value
    bwd_reload_a: assert property (s_bwd_end
        |=> sts_out.count == $past(cfg_in.load_value))
        else $error("backward end reload missing");

    // single mode shuts the gate on the forward reload
    fwd_close_a: assert property (s_fwd_end ##0
        cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE |=> state_q.auto_closed)
        else $error("forward single did not close");

    // single mode shuts the gate on the backward reload
    bwd_close_a: assert property (s_bwd_end ##0
        cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE |=> state_q.auto_closed)
        else $error("backward single did not close");

    // periodic forward reloads and keeps the gate open
    period_fwd_a: assert property (s_fwd_end ##0
        cfg_in.mode == gupc_pkg::GUPC_MODE_PERIOD |=> !state_q.auto_closed)
        else $error("periodic forward closed the gate");

    // periodic backward reloads and keeps the gate open
    period_bwd_a: assert property (s_bwd_end ##0
        cfg_in.mode == gupc_pkg::GUPC_MODE_PERIOD |=> !state_q.auto_closed)
        else $error("periodic backward closed the gate");

    // ------------------------------------------------------------------
    // limit wraps, flags and interrupt
    // ------------------------------------------------------------------
    // single mode wrap at the top closes and flags
    single_wrap_a: assert property (s_up_at_max ##0
        cfg_in.mode == gupc_pkg::GUPC_MODE_SINGLE
        |=> state_q.auto_closed && sts_out.overflow_flag)
        else $error("single wrap did not close");

    // periodic mode never closes the gate by itself
    period_open_a: assert property (cfg_in.mode == gupc_pkg::GUPC_MODE_PERIOD
        && !state_q.auto_closed |=> !state_q.auto_closed)
        else $error("periodic mode closed the gate");

    // underflow flag stays until the clear request
    unf_sticky_a: assert property (sts_out.underflow_flag
        && !status_clear_request_in |=> sts_out.underflow_flag)
        else $error("underflow flag lost");

    // a wrap in the clear cycle still leaves the flag set
    set_wins_a: assert property (status_clear_request_in && ovf
        |=> sts_out.overflow_flag)
        else $error("clear beat a new overflow");

    // every flag-setting wrap pulses the interrupt when enabled
    irq_on_set_a: assert property (cfg_in.irq_en && (ovf || unf)
        |=> sts_out.process_irq)
        else $error("interrupt missing on wrap");

    // ------------------------------------------------------------------
    // gate reopening
    // ------------------------------------------------------------------
    // directed single mode restarts from the load value
    reopen_load_a: assert property (state_q.auto_closed && reopen_ok
        && cfg_in.main_dir != gupc_pkg::GUPC_DIR_NONE
        |=> sts_out.count == $past(cfg_in.load_value))
        else $error("reopen did not load");

    // program gate rise with hardware gate on only continues
    hw_only_a: assert property (cfg_in.hardware_gate_input_en && cfg_in.abort_mode
        && sw_rise && !hw_rise && !state_q.auto_closed && !(up_ev ^ dn_ev)
        |=> $stable(sts_out.count))
        else $error("program gate rise restarted count");

    // interrupt behaviour resumes from the held value
    resume_held_a: assert property (!cfg_in.abort_mode && gate_rise
        && !state_q.auto_closed && !(up_ev ^ dn_ev) |=> $stable(sts_out.count))
        else $error("reopen moved held count");

endmodule // gupc_counter

// *** bench/gupc_enc_model.sv ***
// Purpose: encoder pulse source facing the counter pins
// Assumes: one-cycle request strobes from the bench
// Notes:   each pin pulse is high two cycles, then low
`timescale 1ns/1ps

module gupc_enc_model
(
    input  wire logic mclk_in,
    input  wire logic up_req_in,
    input  wire logic dn_req_in,
    output logic      count_up_out   = 1'b0,
    output logic      count_down_out = 1'b0
);
    // ------------------------------------------------------------------
    // pulse shaper
    // ------------------------------------------------------------------
    logic hold_q = 1'b0;

    // raise one pin, keep it two cycles, then drop both
    always_ff @(posedge mclk_in)
    begin
        if (up_req_in || dn_req_in)
        begin
            count_up_out   <= up_req_in;
            count_down_out <= dn_req_in;
            hold_q         <= 1'b1;
        end
        else if (hold_q)
            hold_q <= 1'b0;
        else
            {count_up_out, count_down_out} <= 2'h0;
    end
endmodule // gupc_enc_model

// *** bench/gupc_counter_tb.sv ***
// Purpose: self-checking bench of the pulse counter
// Assumes: count lands four edges after a pin rise
// Notes:   integer model tracks count, flags and irq
`timescale 1ns/1ps

module gupc_counter_tb;
    logic                mclk_in   = 1'b0;
    logic                rst_in    = 1'b1;
    logic                up_req    = 1'b0;
    logic                dn_req    = 1'b0;
    logic                pin_up;
    logic                pin_dn;
    logic                hardware_gate_input   = 1'b0;
    logic                prog_gate = 1'b0;
    logic                clr       = 1'b0;
    gupc_pkg::gupc_cfg_t cfg       = '0;
    gupc_pkg::gupc_sts_t sts;
    int                  n_mismatch  = 0;
    int                  comparisons = 0;
    int                  seed        = 68267;
    int                  n_irq       = 0;
    int                  e_irq       = 0;
    logic [31:0]         e_cnt       = '0;
    logic                e_ovf       = 1'b0;
    logic                e_unf       = 1'b0;
    logic                closed      = 1'b0;
    logic                gate_ok     = 1'b1;
    logic [31:0]         rnd;

    // ------------------------------------------------------------------
    // design and far side
    // ------------------------------------------------------------------
    gupc_counter dut (.mclk_in(mclk_in), .rst_in(rst_in), .count_up_in(pin_up),
        .count_down_in(pin_dn), .hardware_gate_input_in(hardware_gate_input),
        .program_gate_bit_in(prog_gate), .status_clear_request_in(clr),
        .cfg_in(cfg), .sts_out(sts));
    gupc_enc_model enc (.mclk_in(mclk_in), .up_req_in(up_req), .dn_req_in(dn_req),
        .count_up_out(pin_up), .count_down_out(pin_dn));

    // clock and interrupt pulse counter
    initial
        forever #5 mclk_in = ~mclk_in;
    always @(posedge mclk_in)
        if (sts.process_irq === 1'b1) n_irq++;

    // ------------------------------------------------------------------
    // compare tasks
    // ------------------------------------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("Error at %0t: value %h, expected %h", $time, got, want);
        end
    endtask

    task automatic chk1(input logic got, input logic want);
        comparisons++;
        if (got !== want)
        begin
            n_mismatch++;
            $display("Error at %0t: flag %b, expected %b", $time, got, want);
        end
    endtask

    task automatic check_all();
        chk32(sts.count, e_cnt);
        chk1(sts.overflow_flag, e_ovf);
        chk1(sts.underflow_flag, e_unf);
        chk32(n_irq, e_irq);
    endtask

    // ------------------------------------------------------------------
    // stimulus tasks with the model
    // ------------------------------------------------------------------
    task automatic pulse(input logic up);
        logic sgl;
        logic nodir;
        sgl   = (cfg.mode == gupc_pkg::GUPC_MODE_SINGLE);
        nodir = (cfg.main_dir == gupc_pkg::GUPC_DIR_NONE);
        @(posedge mclk_in);
        up_req <= up;
        dn_req <= !up;
        @(posedge mclk_in);
        {up_req, dn_req} <= 2'h0;
        repeat (7) @(posedge mclk_in);
        // end-value reload first, then limit wraps, else step of one
        if (!closed && gate_ok)
        begin
            if ((cfg.main_dir == gupc_pkg::GUPC_DIR_FWD && up && e_cnt == cfg.end_value - 1)
                || (cfg.main_dir == gupc_pkg::GUPC_DIR_BWD && !up && e_cnt == cfg.end_value + 1))
                {e_cnt, closed} = {cfg.load_value, sgl};
            else if (up && e_cnt == gupc_pkg::LIMIT_MAX)
                {e_cnt, e_ovf, closed, e_irq} = {gupc_pkg::LIMIT_MIN, 1'b1, sgl && nodir, e_irq + 1};
            else if (!up && e_cnt == gupc_pkg::LIMIT_MIN)
                {e_cnt, e_unf, closed, e_irq} = {gupc_pkg::LIMIT_MAX, 1'b1, sgl && nodir, e_irq + 1};
            else
                e_cnt = up ? e_cnt + 1 : e_cnt - 1;
        end
        check_all();
    endtask

    // program gate fall then rise; abort or directed restart reloads
    task automatic reopen();
        @(posedge mclk_in);
        prog_gate <= 1'b0;
        repeat (2) @(posedge mclk_in);
        prog_gate <= 1'b1;
        repeat (3) @(posedge mclk_in);
        if (cfg.abort_mode || (closed && cfg.main_dir != gupc_pkg::GUPC_DIR_NONE))
            e_cnt = cfg.load_value;
        closed = 1'b0;
        check_all();
    endtask

    task automatic clear();
        @(posedge mclk_in);
        clr <= 1'b1;
        @(posedge mclk_in);
        clr <= 1'b0;
        repeat (2) @(posedge mclk_in);
        {e_ovf, e_unf} = 2'h0;
        check_all();
    endtask

    task automatic setup(input gupc_pkg::gupc_mode_t m, input gupc_pkg::gupc_dir_t d,
                         input logic [31:0] ld, input logic [31:0] ev, input logic ab);
        @(posedge mclk_in);
        cfg <= '{mode: m, main_dir: d, hardware_gate_input_en: 1'b0, abort_mode: 1'b1,
                 irq_en: 1'b1, load_value: ld, end_value: ev};
        @(posedge mclk_in);
        reopen();
        clear();
        cfg.abort_mode <= ab;
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        setup(gupc_pkg::GUPC_MODE_CONT, gupc_pkg::GUPC_DIR_NONE, 32'h7FFFFFFE, 32'h0, 1'b1);
        pulse(1'b1);
        pulse(1'b1);
        pulse(1'b0);
        clear();
        $display("test continuous done");
        setup(gupc_pkg::GUPC_MODE_SINGLE, gupc_pkg::GUPC_DIR_NONE, 32'h80000001, 32'h0, 1'b0);
        repeat (2) pulse(1'b0);
        chk1(sts.gate_open, 1'b0);
        pulse(1'b0);
        reopen();
        pulse(1'b0);
        setup(gupc_pkg::GUPC_MODE_SINGLE, gupc_pkg::GUPC_DIR_FWD, 32'h5, 32'h8, 1'b0);
        repeat (4) pulse(1'b1);
        reopen();
        setup(gupc_pkg::GUPC_MODE_SINGLE, gupc_pkg::GUPC_DIR_BWD, 32'h3, 32'h0, 1'b0);
        repeat (4) pulse(1'b0);
        reopen();
        $display("test single done");
        rnd = $random(seed) & 32'hFFFF;
        setup(gupc_pkg::GUPC_MODE_PERIOD, gupc_pkg::GUPC_DIR_FWD, rnd, rnd + 3, 1'b0);
        repeat (4) pulse(1'b1);
        setup(gupc_pkg::GUPC_MODE_PERIOD, gupc_pkg::GUPC_DIR_BWD, 32'h7FFFFFFF, 32'h0, 1'b0);
        pulse(1'b1);
        setup(gupc_pkg::GUPC_MODE_PERIOD, gupc_pkg::GUPC_DIR_NONE, 32'h80000000, 32'h0, 1'b0);
        pulse(1'b0);
        chk1(sts.gate_open, 1'b1);
        $display("test periodic done");
        for (int a = 0; a < 2; a++)
        begin
            rnd = $random(seed) & 32'hFFFFF;
            setup(gupc_pkg::GUPC_MODE_CONT, gupc_pkg::GUPC_DIR_NONE, rnd, 32'h0, a[0]);
            repeat (2) pulse(1'b1);
            reopen();
            pulse(1'b0);
        end
        // hardware gate low closes, its rise restarts with abort
        @(posedge mclk_in);
        cfg.hardware_gate_input_en <= 1'b1;
        cfg.abort_mode <= 1'b1;
        gate_ok = 1'b0;
        pulse(1'b1);
        hardware_gate_input <= 1'b1;
        repeat (8) @(posedge mclk_in);
        gate_ok = 1'b1;
        e_cnt = cfg.load_value;
        check_all();
        pulse(1'b1);
        $display("test gate done");
        summarize();
    end

    // watchdog well beyond the few hundred cycles the tests need
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end
endmodule // gupc_counter_tb
